// ===== rtl/rfc_pkg.sv
//////////////////////////////////////////////////////////////////////////////////////////
// Purpose : shared constants, types and helpers of the receive flow controller
// Assumes : 250 MHz core clock, receive FIFO level counted in bytes
// Notes   : jam tables are given in microseconds and turned into cycles here
//////////////////////////////////////////////////////////////////////////////////////////
package rfc_pkg;

  // clock and threshold granularity
  localparam int CLK_PERIOD_NS     = 4;
  localparam int THR_UNIT_SHIFT    = 6;     // thresholds count 64-byte blocks
  localparam int THR_FIELD_W       = 8;
  localparam int THR_BYTES_W       = THR_FIELD_W + THR_UNIT_SHIFT;
  localparam int LEVEL_W_DEF       = 14;    // 16 KB receive FIFO
  localparam int JAM_CODES         = 16;
  localparam int JAM_CNT_W         = 18;    // holds 602.2 us at 4 ns

  // jam durations at 100 Mb/s, in microseconds, indexed by duration code
  localparam int JAM_US_100 [JAM_CODES] = '{5, 10, 15, 25, 50, 100, 150, 200,
                                            250, 300, 350, 400, 450, 500, 550, 600};
  // extra jam time at 10 Mb/s, in nanoseconds
  localparam int JAM_EXTRA_10M_NS  = 2200;
  // least time: round up to whole cycles
  localparam int JAM_EXTRA_10M_CYC = (JAM_EXTRA_10M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef int unsigned rfc_jam_tbl_t [JAM_CODES];

  // configuration bits, held steady by software
  typedef struct packed {
    logic                   any_frame_trigger;
    logic                   multicast_trigger;
    logic                   broadcast_trigger;
    logic                   address_match_trigger;
    logic [3:0]             jam_duration_code;
    logic [THR_FIELD_W-1:0] flow_high_threshold;
    logic [THR_FIELD_W-1:0] flow_low_threshold;
  } rfc_cfg_t;

  // receive frame classification from the MAC receiver
  typedef struct packed {
    logic preamble;       // one-cycle pulse: valid preamble seen
    logic addr_valid;     // one-cycle pulse: destination decoded
    logic address_match;
    logic broadcast;
    logic multicast;
  } rfc_rx_t;

  // pause request towards the MAC transmitter
  typedef struct packed {
    logic req;            // level, held until the transmitter accepts it
    logic zero_time;      // 1: pause time of zero (resume)
  } rfc_pause_t;

  localparam rfc_pause_t PAUSE_RST  = '{req: 1'b0, zero_time: 1'b0};
  localparam rfc_pause_t PAUSE_HOLD = '{req: 1'b1, zero_time: 1'b0};
  localparam rfc_pause_t PAUSE_FREE = '{req: 1'b1, zero_time: 1'b1};

  // jam table in cycles at 100 Mb/s, exact for a 4 ns clock
  function automatic rfc_jam_tbl_t rfc_jam_cycles();
    rfc_jam_tbl_t t;
    for (int i = 0; i < JAM_CODES; i++) begin
      t[i] = int'((JAM_US_100[i] * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    end
    return t;
  endfunction : rfc_jam_cycles

  // threshold field to a byte count
  function automatic logic [THR_BYTES_W-1:0] rfc_thr_bytes(logic [THR_FIELD_W-1:0] thr);
    return {thr, {THR_UNIT_SHIFT{1'b0}}};
  endfunction : rfc_thr_bytes

endpackage : rfc_pkg

// ===== rtl/rfc_jam_timer.sv
//////////////////////////////////////////////////////////////////////////////////////////
// Purpose : one-shot jam timer, active for exactly the loaded number of cycles
// Assumes : load value is at least one
// Notes   : a load while active restarts the timer from the new value
//////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module rfc_jam_timer #(
  parameter int CNT_W = 18
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_count,
  output logic                  o_active
);

  logic [CNT_W-1:0] cnt_q;

  // active from the cycle after the load for i_count cycles
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q    <= '0;
      o_active <= 1'b0;
    end else if (i_load) begin
      cnt_q    <= i_count;
      o_active <= 1'b1;
    end else if (o_active) begin
      cnt_q    <= cnt_q - CNT_W'(1);
      o_active <= (cnt_q != CNT_W'(1));
    end
  end

endmodule : rfc_jam_timer

// ===== rtl/rfc_flow_ctrl.sv
//////////////////////////////////////////////////////////////////////////////////////////
// Purpose : automatic receive flow control: jam in half duplex, pause in full duplex
// Assumes : all inputs come from logic on the core clock; config held steady
// Notes   : the pause request is a level held until the transmitter accepts it
//
// Summary of operation
// - any-frame mode: act on threshold plus frame in half duplex, threshold alone in full duplex
// - full-duplex pause only with any-frame set
// - half-duplex any-frame ignores destination address
// - half-duplex any-frame jams at next preamble
// - full-duplex any-frame pauses right at threshold
// - pause request held until transmitter takes it
// - any-frame overrides the three selective triggers
// - duration code picks jam time, 10M longer
// - high threshold counts 64-byte blocks
// - zero pause only after pause, below low
// - jam held for code time, half duplex
// - half duplex selective jam per trigger bits
//////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module rfc_flow_ctrl
  import rfc_pkg::*;
#(
  parameter int                    LEVEL_W       = rfc_pkg::LEVEL_W_DEF,
  parameter rfc_pkg::rfc_jam_tbl_t P_JAM_CYC_100 = rfc_pkg::rfc_jam_cycles()
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire rfc_pkg::rfc_cfg_t i_cfg,
  input  wire logic              i_full_duplex,
  input  wire logic              i_speed_100,
  input  wire logic [LEVEL_W-1:0] i_rx_level,
  input  wire rfc_pkg::rfc_rx_t  i_rx,
  input  wire logic              i_pause_ack,
  output rfc_pkg::rfc_pause_t    o_pause,
  output logic                   o_jam,
  output logic                   o_paused
);

  //////////////////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;

  // async assert, release after two edges so no flop sees a ragged release
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  //////////////////////////////////////////////////////////////////////////////////////////
  // threshold compare
  logic hi_reached;
  logic below_lo;
  logic fd_auto;

  // levels compared as bytes; low above high is software's fault
  assign hi_reached = int'(i_rx_level) >= int'(rfc_thr_bytes(i_cfg.flow_high_threshold));
  assign below_lo   = int'(i_rx_level) < int'(rfc_thr_bytes(i_cfg.flow_low_threshold));
  assign fd_auto    = i_full_duplex && i_cfg.any_frame_trigger;

  //////////////////////////////////////////////////////////////////////////////////////////
  // full duplex pause requests
  logic issue_hold;
  logic issue_free;

  // a new request only while none is pending, so an accept is never lost
  assign issue_hold = fd_auto && !o_pause.req && !o_paused && hi_reached;
  assign issue_free = fd_auto && !o_pause.req && o_paused && below_lo;

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pause <= PAUSE_RST;
    end else if (issue_hold) begin
      o_pause <= PAUSE_HOLD;
    end else if (issue_free) begin
      o_pause <= PAUSE_FREE;
    end else if (i_pause_ack) begin
      o_pause.req <= 1'b0;
    end
  end

  // remembers a pause was sent so a single one goes out per excursion
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_paused <= 1'b0;
    end else if (issue_hold) begin
      o_paused <= 1'b1;
    end else if (issue_free) begin
      o_paused <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // half duplex jam triggers
  logic                 hd_any_hit;
  logic                 hd_sel_hit;
  logic                 jam_load;
  logic [JAM_CNT_W-1:0] jam_cycles;

  // any-frame: no address decode, act on the preamble of the next frame
  assign hd_any_hit = !i_full_duplex && i_cfg.any_frame_trigger && hi_reached
                      && i_rx.preamble;
  // selective triggers only when any-frame is clear
  assign hd_sel_hit = !i_full_duplex && !i_cfg.any_frame_trigger && hi_reached
                      && i_rx.addr_valid
                      && ((i_cfg.multicast_trigger && i_rx.multicast)
                       || (i_cfg.broadcast_trigger && i_rx.broadcast)
                       || (i_cfg.address_match_trigger && i_rx.address_match));
  assign jam_load   = hd_any_hit || hd_sel_hit;

  // duration from the table, plus the fixed extra at 10 Mb/s
  assign jam_cycles = JAM_CNT_W'(P_JAM_CYC_100[i_cfg.jam_duration_code]
                      + (i_speed_100 ? 0 : JAM_EXTRA_10M_CYC));

  rfc_jam_timer #(
    .CNT_W      (JAM_CNT_W)
  ) u_jam_timer (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n),
    .i_load     (jam_load),
    .i_count    (jam_cycles),
    .o_active   (o_jam)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // checks
  logic [JAM_CNT_W-1:0] chk_len_q;
  logic [JAM_CNT_W-1:0] chk_exp_q;
  logic                 zero_req;

  // measures each jam against the length loaded for it
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_len_q <= '0;
      chk_exp_q <= '0;
    end else if (jam_load) begin
      chk_len_q <= '0;
      chk_exp_q <= jam_cycles;
    end else if (o_jam) begin
      chk_len_q <= chk_len_q + JAM_CNT_W'(1);
    end
  end
  assign zero_req = o_pause.req && o_pause.zero_time;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  property p_any_preamble;
    !i_full_duplex && i_cfg.any_frame_trigger && hi_reached && i_rx.preamble |=> o_jam;
  endproperty
  a_any_preamble: assert property (p_any_preamble) else $error("no jam on preamble");

  property p_no_addr_decode;
    !i_full_duplex && i_cfg.any_frame_trigger && hi_reached && i_rx.preamble
      && !i_rx.address_match && !i_rx.broadcast && !i_rx.multicast |=> o_jam;
  endproperty
  a_no_addr_decode: assert property (p_no_addr_decode) else $error("jam gated by addr");

  property p_any_overrides;
    !o_jam && i_cfg.any_frame_trigger && !i_rx.preamble |=> !o_jam;
  endproperty
  a_any_overrides: assert property (p_any_overrides) else $error("selective jam in any");

  property p_sel_multicast;
    !i_full_duplex && !i_cfg.any_frame_trigger && hi_reached && i_rx.addr_valid
      && i_cfg.multicast_trigger && i_rx.multicast |=> o_jam;
  endproperty
  a_sel_multicast: assert property (p_sel_multicast) else $error("no multicast jam");

  property p_jam_length;
    $fell(o_jam) |-> chk_len_q == chk_exp_q;
  endproperty
  a_jam_length: assert property (p_jam_length) else $error("jam length wrong");

  property p_no_jam_fd;
    i_full_duplex && !o_jam |=> !o_jam;
  endproperty
  a_no_jam_fd: assert property (p_no_jam_fd) else $error("jam in full duplex");

  property p_fd_pause_now;
    fd_auto && hi_reached && !o_paused && !o_pause.req |=> o_pause.req && !o_pause.zero_time;
  endproperty
  a_fd_pause_now: assert property (p_fd_pause_now) else $error("pause not requested");

  property p_pause_needs_any;
    $rose(o_pause.req) |-> $past(i_cfg.any_frame_trigger) && $past(i_full_duplex);
  endproperty
  a_pause_needs_any: assert property (p_pause_needs_any) else $error("pause without any");

  property p_pause_held;
    o_pause.req && !i_pause_ack |=> o_pause.req && $stable(o_pause.zero_time);
  endproperty
  a_pause_held: assert property (p_pause_held) else $error("pause dropped unacked");

  property p_zero_cause;
    $rose(zero_req) |-> $past(o_paused) && $past(below_lo);
  endproperty
  a_zero_cause: assert property (p_zero_cause) else $error("stray zero pause");

  property p_hold_needs_hi;
    $rose(o_pause.req) && !o_pause.zero_time |-> $past(hi_reached);
  endproperty
  a_hold_needs_hi: assert property (p_hold_needs_hi) else $error("pause below high");

  property p_idle_no_pause;
    !fd_auto && !o_pause.req |=> !o_pause.req;
  endproperty
  a_idle_no_pause: assert property (p_idle_no_pause) else $error("pause while disabled");

  property p_ack_clears;
    o_pause.req && i_pause_ack |=> !o_pause.req;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("pause kept after ack");

  // a jam may only begin from a half-duplex trigger
  property p_jam_hd_start;
    $rose(o_jam) |-> !$past(i_full_duplex);
  endproperty
  a_jam_hd_start: assert property (p_jam_hd_start) else $error("jam from full duplex");

endmodule : rfc_flow_ctrl

// ===== verif/rfc_tx_model.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose : transmitter side that takes pause requests from the flow controller
// Assumes : request is a level held until this side pulses the acknowledge
// Notes   : i_delay stands for a frame already on the wire, never aborted
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module rfc_tx_model
  import rfc_pkg::*;
(
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  input  wire rfc_pkg::rfc_pause_t i_pause,
  input  wire logic [2:0]         i_delay,
  output logic                    o_ack
);
  logic [2:0] wait_q;

  // pending pause goes out at the next free slot, after the current frame
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack  <= 1'b0;
      wait_q <= 3'h0;
    end else if (o_ack) begin
      o_ack  <= 1'b0;  // one pulse only; request drops after it
      wait_q <= 3'h0;
    end else if (i_pause.req && wait_q >= i_delay) begin
      o_ack  <= 1'b1;
    end else if (i_pause.req) begin
      wait_q <= wait_q + 3'h1;
    end
  end
endmodule : rfc_tx_model

// ===== verif/rfc_flow_ctrl_tb.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose : self-checking bench of the receive flow controller
// Assumes : short jam table so a full sweep of codes stays brief
// Notes   : inputs change on the falling edge, outputs sampled there too
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module rfc_flow_ctrl_tb;
  import rfc_pkg::*;
  localparam rfc_jam_tbl_t JT = '{20, 23, 26, 29, 32, 35, 38, 41,
                                  44, 47, 50, 53, 56, 59, 62, 65};
  logic        i_core_clk, i_rst_n, fd, s100, ack;
  rfc_cfg_t    cfg;
  rfc_rx_t     rx;
  rfc_cfg_t    cv;
  rfc_rx_t     rv;
  localparam rfc_jam_tbl_t JDEF = rfc_jam_cycles();
  logic [13:0] lvl;
  logic [2:0]  dly;
  rfc_pause_t  pause;
  logic        jam, paused;
  int          n_errors, comparisons, n, k, ex;

  rfc_flow_ctrl #(.LEVEL_W(14), .P_JAM_CYC_100(JT)) i_rfc_flow_ctrl (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cfg(cfg), .i_full_duplex(fd),
    .i_speed_100(s100), .i_rx_level(lvl), .i_rx(rx), .i_pause_ack(ack),
    .o_pause(pause), .o_jam(jam), .o_paused(paused));
  rfc_tx_model i_rfc_tx_model (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_pause(pause), .i_delay(dly), .o_ack(ack));

  // 250 MHz clock
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  // pulse one classification, then count cycles of jam
  task automatic jam_run(input rfc_rx_t v, output int cnt);
    rx = v;
    @(negedge i_core_clk);
    rx  = '0;
    cnt = 0;
    for (int j = 0; j < 2 && jam !== 1'b1; j++) @(negedge i_core_clk);
    while (jam === 1'b1 && cnt < 3000) begin
      cnt++;
      @(negedge i_core_clk);
    end
    if (cnt >= 3000) begin
      n_errors++;
      complete_run();
    end
  endtask : jam_run

  // bounded wait for the pause request to reach a level
  task automatic wait_req(input logic v);
    k = 0;
    while (pause.req !== v && k < 50) begin
      @(negedge i_core_clk);
      k++;
    end
    if (k == 50) begin
      n_errors++;
      complete_run();
    end
  endtask : wait_req

  initial begin
    n_errors = 0; comparisons = 0;
    i_rst_n = 1'b0; cfg = '0; fd = 1'b0; s100 = 1'b1; lvl = 14'h0; rx = '0; dly = 3'h0;
    void'($urandom(59864));
    repeat (16) @(negedge i_core_clk);
    chk(jam, 0);
    chk(pause.req, 0);
    // default jam table against the rule's microsecond steps, 250 cycles per us
    for (int c = 0; c < 16; c++) begin
      ex = (c < 3) ? 5 * (c + 1) : (c == 3) ? 25 : 50 * (c - 3);
      chk(JDEF[c], ex * 250);
    end
    chk(JAM_EXTRA_10M_CYC, 550);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_core_clk);
    // random sweep of triggers, codes, speeds, levels around threshold
    for (int i = 0; i < 48; i++) begin
      cv = rfc_cfg_t'(24'($urandom));
      cv.jam_duration_code = 4'(i % 16);
      cv.flow_high_threshold = 8'h04 + 8'($urandom % 200);
      fd = ($urandom % 4) == 0;
      if (fd) cv.any_frame_trigger = 1'b0;
      cfg = cv;
      s100 = 1'($urandom % 2);
      lvl = {cfg.flow_high_threshold, 6'h00} - 14'($urandom % 2);
      rv = rfc_rx_t'(5'($urandom));
      ex = 0;
      if (!fd && lvl >= cfg.flow_high_threshold * 64 && (cfg.any_frame_trigger ? rv.preamble
          : rv.addr_valid && (cfg.multicast_trigger && rv.multicast
          || cfg.broadcast_trigger && rv.broadcast
          || cfg.address_match_trigger && rv.address_match)))
        ex = JT[cfg.jam_duration_code] + (s100 ? 0 : 550);
      jam_run(rv, n);
      chk(n, ex);
      chk(pause.req, 0);
    end
    // full duplex: pause at threshold, zero pause below low
    cfg = '{any_frame_trigger: 1'b1, flow_high_threshold: 8'h08,
            flow_low_threshold: 8'h04, default: '0};
    fd = 1'b1;
    for (int r = 0; r < 2; r++) begin
      dly = 3'($urandom % 8);
      lvl = 14'h0200;
      wait_req(1'b1);
      chk({pause.zero_time, paused}, 2'h1);
      jam_run(5'h10, n);
      chk(n, 0);
      wait_req(1'b0);
      repeat (10) @(negedge i_core_clk);
      chk(pause.req, 0);
      lvl = 14'h0100;
      repeat (10) @(negedge i_core_clk);
      chk(pause.req, 0);
      lvl = 14'h00FF;
      wait_req(1'b1);
      chk({pause.zero_time, paused}, 2'h2);
      wait_req(1'b0);
    end
    complete_run();
  end
endmodule : rfc_flow_ctrl_tb
